// file: verilog/chan_ctrl_pkg.sv
// package: channel control register layout, offsets and shared types
package chan_ctrl_pkg;
   localparam int NUM_CHANNELS = 4;
   localparam int CHAN_W = 2;
   // byte offsets on the register bus (one aligned word per register)
   localparam logic [5:0] OFF_CTRL0 = 6'h00;
   localparam logic [5:0] OFF_CTRL1 = 6'h04;
   localparam logic [5:0] OFF_CTRL2 = 6'h08;
   localparam logic [5:0] OFF_CTRL3 = 6'h0C;
   localparam logic [5:0] OFF_IRQ_STATUS = 6'h10;
   localparam logic [5:0] OFF_IRQ_MASK = 6'h14;
   localparam logic [5:0] OFF_END_EVENT = 6'h18;
   // field positions inside a channel control word
   localparam int BIT_RSVD_LO = 21;
   localparam int BIT_INDIRECT = 20;
   localparam int BIT_RELOAD = 19;
   localparam int BIT_RCHK_LVL = 18;
   localparam int BIT_ACK_PHASE = 17;
   localparam int BIT_ACK_POL = 16;
   localparam int BIT_REQ_SENSE = 6;
   localparam int BIT_END_FLAG = 1;
   localparam int BIT_DEST_LO = 14; // two-bit destination mode field
   localparam int BIT_SRC_LO = 12; // two-bit source mode field
   localparam int BIT_RES_LO = 8; // four-bit resource select field
   localparam int BIT_XFER_MODE = 5;
   localparam int BIT_SIZE_HI = 4;
   localparam int BIT_SIZE_LO = 3;
   localparam int BIT_INT_EN = 2;
   localparam int BIT_CHAN_EN = 0;
   // channel owning each channel-specific bit
   localparam logic [CHAN_W-1:0] CHAN_INDIRECT = 2'h3;
   localparam logic [CHAN_W-1:0] CHAN_RELOAD = 2'h2;
   // implemented bits per channel; bits 31..21 and bit 7 are never stored
   localparam logic [31:0] MASK_COMMON = 32'h0000_FF3F;
   localparam logic [31:0] MASK_CH01 = 32'h0007_0040;
   localparam logic [31:0] MASK_CH2 = 32'h0008_0000;
   localparam logic [31:0] MASK_CH3 = 32'h0010_0000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // fields handed to the transfer engine
   typedef struct packed {
      logic indirect_addressing_select;
      logic source_reload_select;
      logic request_check_level;
      logic acknowledge_phase_select;
      logic acknowledge_polarity;
      logic [1:0] dest_mode;
      logic [1:0] src_mode;
      logic [3:0] resource_select;
      logic request_sense_select;
      logic bus_transfer_mode;
      logic transfer_size_high;
      logic transfer_size_low;
      logic interrupt_enable_bit;
      logic transfer_end_flag;
      logic channel_enable_bit;
   } chan_fields_type;
endpackage : chan_ctrl_pkg

// file: verilog/chan_field_unpack.sv
// module: splits one stored control word into the engine-facing field struct
`timescale 1ns/1ps
module chan_field_unpack (
   input wire logic [31:0] word_in,
   output chan_ctrl_pkg::chan_fields_type fields_out
);
   import chan_ctrl_pkg::*;
   // pure field mapping, bit positions per the control word layout
   always_comb begin
      fields_out.indirect_addressing_select = word_in[BIT_INDIRECT];
      fields_out.source_reload_select = word_in[BIT_RELOAD];
      fields_out.request_check_level = word_in[BIT_RCHK_LVL];
      fields_out.acknowledge_phase_select = word_in[BIT_ACK_PHASE];
      fields_out.acknowledge_polarity = word_in[BIT_ACK_POL];
      fields_out.dest_mode = word_in[BIT_DEST_LO +: 2];
      fields_out.src_mode = word_in[BIT_SRC_LO +: 2];
      fields_out.resource_select = word_in[BIT_RES_LO +: 4];
      fields_out.request_sense_select = word_in[BIT_REQ_SENSE];
      fields_out.bus_transfer_mode = word_in[BIT_XFER_MODE];
      fields_out.transfer_size_high = word_in[BIT_SIZE_HI];
      fields_out.transfer_size_low = word_in[BIT_SIZE_LO];
      fields_out.interrupt_enable_bit = word_in[BIT_INT_EN];
      fields_out.transfer_end_flag = word_in[BIT_END_FLAG];
      fields_out.channel_enable_bit = word_in[BIT_CHAN_EN];
   end
endmodule : chan_field_unpack

// file: verilog/dma_channel_control_reg.sv
// module: four channel control registers with AXI4-Lite access and end interrupt
//
// Contract
// (RQ1) after reading end flag one, only zero written
// (RQ2) bits 31 to 21 read zero
// (RQ3) indirect select exists only on channel 3
// (RQ4) indirect select: 0 direct, 1 indirect, resets 0
// (RQ5) software uses direct addressing for 16-byte size
// (RQ6) channel-specific bits implemented only in some channels
// (RQ7) reload select chooses channel 2 source reload
// (RQ8) reload select exists only on channel 2
// (RQ9) software keeps reload zero for 16-byte size
// (RQ10) reset clears all implemented fields to zero
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module dma_channel_control_reg (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // write address channel
   input wire logic [5:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   // write data channel
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // write response channel
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // read address channel
   input wire logic [5:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   // read data channel
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // transfer-end pulses from the engine, one bit per channel
   input wire logic [3:0] transfer_done_in,
   // control fields toward the engine
   output chan_ctrl_pkg::chan_fields_type [3:0] chan_fields_out,
   output logic irq_out
);
   import chan_ctrl_pkg::*;

   logic [31:0] ctrl_ff [NUM_CHANNELS]; // stored control words
   logic [3:0] irq_status_ff; // sticky end events
   logic [3:0] irq_mask_ff; // 1 lets the event reach irq_out
   logic [5:0] aw_addr_ff; // latched write address
   logic aw_have_ff; // write address held
   logic [31:0] w_data_ff; // latched write data
   logic [3:0] w_strb_ff; // latched byte strobes
   logic w_have_ff; // write data held
   logic irq_ff; // registered interrupt level
   logic [31:0] ctrl_word [NUM_CHANNELS]; // words feeding the unpackers
   logic wr_fire; // both halves of a write present
   logic rd_fire; // read address accepted

   // bits writable in a given channel
   function automatic logic [31:0] chan_mask(input logic [CHAN_W-1:0] ch);
      logic [31:0] m;
      m = MASK_COMMON;
      if (ch == CHAN_INDIRECT) begin
         m = m | MASK_CH3; // see (RQ3) see (RQ6)
      end else if (ch == CHAN_RELOAD) begin
         m = m | MASK_CH2; // see (RQ8) see (RQ6)
      end else begin
         m = m | MASK_CH01; // see (RQ6)
      end
      return m;
   endfunction : chan_mask

   // byte strobes expanded to a bit mask
   function automatic logic [31:0] strb_bits(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : strb_bits

   // true when the offset selects a channel control register, word aligned
   function automatic logic is_ctrl(input logic [5:0] a);
      return (a[5:4] == OFF_CTRL0[5:4]) && (a[1:0] == 2'h0);
   endfunction : is_ctrl

   assign wr_fire = aw_have_ff && w_have_ff && !s_axi_bvalid_out;
   assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;

   // write address capture
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         aw_have_ff <= 1'b0;
         aw_addr_ff <= 6'h00;
         s_axi_awready_out <= 1'b0;
      end else if (wr_fire) begin
         aw_have_ff <= 1'b0;
         s_axi_awready_out <= 1'b0;
      end else if (s_axi_awvalid_in && s_axi_awready_out) begin
         aw_have_ff <= 1'b1;
         aw_addr_ff <= s_axi_awaddr_in;
         s_axi_awready_out <= 1'b0;
      end else begin
         s_axi_awready_out <= !aw_have_ff && !s_axi_bvalid_out;
      end
   end

   // write data capture, independent of address order
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         w_have_ff <= 1'b0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         s_axi_wready_out <= 1'b0;
      end else if (wr_fire) begin
         w_have_ff <= 1'b0;
         s_axi_wready_out <= 1'b0;
      end else if (s_axi_wvalid_in && s_axi_wready_out) begin
         w_have_ff <= 1'b1;
         w_data_ff <= s_axi_wdata_in;
         w_strb_ff <= s_axi_wstrb_in;
         s_axi_wready_out <= 1'b0;
      end else begin
         s_axi_wready_out <= !w_have_ff && !s_axi_bvalid_out;
      end
   end

   // write response, error for unmapped offsets
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out <= (is_ctrl(aw_addr_ff) || aw_addr_ff == OFF_IRQ_STATUS
                             || aw_addr_ff == OFF_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   // control words: masked writes, end flag set by the engine
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            ctrl_word_reset: ctrl_ff[i] <= CTRL_RESET; // see (RQ10)
         end
      end else begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            logic [31:0] wm;
            logic [31:0] nxt_word;
            wm = 32'h0000_0000;
            if (wr_fire && is_ctrl(aw_addr_ff) && aw_addr_ff[3:2] == i[1:0]) begin
               // only implemented bits change; reserved stay zero
               wm = strb_bits(w_strb_ff) & chan_mask(i[1:0]); // see (RQ2) see (RQ3) see (RQ8)
            end
            // end flag is write-zero-only; a written one never sets it
            wm[BIT_END_FLAG] = wm[BIT_END_FLAG] & !w_data_ff[BIT_END_FLAG]; // see (RQ1)
            nxt_word = (ctrl_ff[i] & ~wm) | (w_data_ff & wm);
            // a done pulse wins over a clear in the same cycle
            if (transfer_done_in[i]) begin
               nxt_word[BIT_END_FLAG] = 1'b1;
            end
            ctrl_ff[i] <= nxt_word;
         end
      end
   end

   // sticky interrupt status (write one to clear) and mask
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_status_ff <= 4'h0;
         irq_mask_ff <= 4'h0;
      end else begin
         logic [3:0] clr;
         clr = 4'h0;
         if (wr_fire && aw_addr_ff == OFF_IRQ_STATUS && w_strb_ff[0]) begin
            clr = w_data_ff[3:0];
         end
         if (wr_fire && aw_addr_ff == OFF_IRQ_MASK && w_strb_ff[0]) begin
            irq_mask_ff <= w_data_ff[3:0];
         end
         // set beats clear in the same cycle
         irq_status_ff <= (irq_status_ff & ~clr) | transfer_done_in;
      end
   end

   // interrupt level: unmasked status with channel interrupt enable
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_ff <= 1'b0;
      end else begin
         logic any;
         any = 1'b0;
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            any = any | (irq_status_ff[i] & irq_mask_ff[i] & ctrl_ff[i][BIT_INT_EN]);
         end
         irq_ff <= any;
      end
   end
   assign irq_out = irq_ff;

   // read channel, one outstanding read
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rresp_out <= RESP_OKAY;
         if (is_ctrl(s_axi_araddr_in)) begin
            // reserved and absent bits are never stored, so read zero
            s_axi_rdata_out <= ctrl_ff[s_axi_araddr_in[3:2]]; // see (RQ2)
         end else if (s_axi_araddr_in == OFF_IRQ_STATUS) begin
            s_axi_rdata_out <= {28'h0000000, irq_status_ff};
         end else if (s_axi_araddr_in == OFF_IRQ_MASK) begin
            s_axi_rdata_out <= {28'h0000000, irq_mask_ff};
         end else begin
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= RESP_SLVERR;
         end
      end else if (s_axi_rvalid_out) begin
         if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end else begin
         s_axi_arready_out <= 1'b1;
      end
   end

   // field views toward the engine
   always_comb begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         ctrl_word[i] = ctrl_ff[i]; // see (RQ4) see (RQ7)
      end
   end
   for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_unpack
      chan_field_unpack u_unpack (
         .word_in(ctrl_word[g]),
         .fields_out(chan_fields_out[g])
      );
   end

   // reserved bits never hold a one
   rsvd_zero_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see (RQ2)
      s_axi_rvalid_out |-> s_axi_rdata_out[31:BIT_RSVD_LO] == 11'h000)
      else $error("reserved bits read nonzero");
   indirect_only_ch3_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see (RQ3)
      !ctrl_ff[0][BIT_INDIRECT] && !ctrl_ff[1][BIT_INDIRECT] && !ctrl_ff[2][BIT_INDIRECT])
      else $error("indirect select set outside channel 3");
   reload_only_ch2_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see (RQ8)
      !ctrl_ff[0][BIT_RELOAD] && !ctrl_ff[1][BIT_RELOAD] && !ctrl_ff[3][BIT_RELOAD])
      else $error("reload select set outside channel 2");
   ch01_bits_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see (RQ6)
      ctrl_ff[2][BIT_RCHK_LVL:BIT_ACK_POL] == 3'h0 && ctrl_ff[3][BIT_REQ_SENSE] == 1'b0)
      else $error("channel 0/1 bits set in channel 2 or 3");
   end_flag_write_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see (RQ1)
      !ctrl_ff[0][BIT_END_FLAG] && !transfer_done_in[0] ##1 1'b1 |-> !ctrl_ff[0][BIT_END_FLAG])
      else $error("end flag set without done pulse");
   done_sets_flag_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see (RQ1)
      transfer_done_in[3] |=> ctrl_ff[3][BIT_END_FLAG] && irq_status_ff[3])
      else $error("done pulse lost");
   reset_clear_a: assert property (@(posedge sys_clk_in) // see (RQ10)
      rst_in |=> ctrl_ff[3] == CTRL_RESET && ctrl_ff[2] == CTRL_RESET && !irq_out)
      else $error("control not cleared by reset");
   indirect_view_a: assert property (@(posedge sys_clk_in) disable iff (rst_in) // see (RQ4)
      chan_fields_out[3].indirect_addressing_select == ctrl_ff[3][BIT_INDIRECT]
      && chan_fields_out[2].source_reload_select == ctrl_ff[2][BIT_RELOAD]) // see (RQ7)
      else $error("engine field view mismatch");
endmodule : dma_channel_control_reg

// file: verification/dma_channel_control_reg_tb.sv
// testbench: register bus access, channel-specific bits, end flag and interrupt
`timescale 1ns/1ps
module dma_channel_control_reg_tb;
   import chan_ctrl_pkg::*;
   logic sys_clk_in; // 50 MHz bench clock
   logic rst_in; // synchronous reset, active high
   logic [5:0] awaddr, araddr; // bus addresses
   logic awvalid, wvalid, bready, arvalid, rready; // master handshakes
   logic [31:0] wdata; // write payload
   logic [3:0] wstrb; // byte enables
   logic awready, wready, bvalid, arready, rvalid, irq; // slave handshakes and interrupt
   logic [1:0] bresp, rresp; // responses
   logic [31:0] rdata; // read payload
   logic [3:0] done; // transfer-end pulses
   chan_fields_type [3:0] fields; // engine-facing field views
   int bad_count; // mismatches
   int tests_run; // comparisons made
   logic [31:0] rd; // read result
   logic [1:0] rs; // response result
   logic [31:0] exp_word [4]; // expected read-back after the fill write
   logic [31:0] wr_word [4]; // fill write value per channel

   // clock generation
   initial sys_clk_in = 1'b0;
   always #10 sys_clk_in = ~sys_clk_in;

   dma_channel_control_reg dut_u (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
      .transfer_done_in(done), .chan_fields_out(fields), .irq_out(irq)
   );

   // prints the verdict and ends the run
   task automatic report_and_stop();
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : report_and_stop

   // compares a word
   task automatic check32(input string name, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask : check32

   // compares a single flag
   task automatic check1(input string name, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %b seen %b", name, e, g);
      end
   endtask : check1

   // one write: address and data offered together, each released when taken
   task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_ok;
      bit w_ok;
      bit b_ok;
      aw_ok = 0;
      w_ok = 0;
      b_ok = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_ok) begin
         @(posedge sys_clk_in);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
         if (bvalid === 1'b1) begin
            b_ok = 1;
            r = bresp;
         end
      end
   endtask : axi_write

   // one read: address held until taken, rready held until data arrives
   task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      bit ar_ok;
      bit r_ok;
      ar_ok = 0;
      r_ok = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!r_ok) begin
         @(posedge sys_clk_in);
         if (!ar_ok && arready === 1'b1) begin
            ar_ok = 1;
            arvalid <= 1'b0;
         end
         if (rvalid === 1'b1) begin
            r_ok = 1;
            d = rdata;
            r = rresp;
         end
      end
   endtask : axi_read

   // holds reset for five cycles
   task automatic do_reset();
      rst_in <= 1'b1;
      repeat (5) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask : do_reset

   // watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk_in);
      bad_count++;
      report_and_stop();
   end

   // main sequence
   initial begin
      bad_count = 0;
      tests_run = 0;
      {awaddr, araddr, wdata, wstrb, done} <= '0;
      {awvalid, wvalid, bready, arvalid, rready} <= '0;
      // bits 31..21 written as zero, reserved bit 7 as one; channels 2 and 3 keep both size bits clear
      wr_word[0] = 32'h001F_FFFF;
      wr_word[1] = 32'h001F_FFFF;
      wr_word[2] = 32'h001F_FFE7;
      wr_word[3] = 32'h001F_FFE7;
      // a written one never sets the end flag
      exp_word[0] = (MASK_COMMON | MASK_CH01) & wr_word[0] & ~32'h0000_0002;
      exp_word[1] = (MASK_COMMON | MASK_CH01) & wr_word[1] & ~32'h0000_0002;
      exp_word[2] = (MASK_COMMON | MASK_CH2) & wr_word[2] & ~32'h0000_0002;
      exp_word[3] = (MASK_COMMON | MASK_CH3) & wr_word[3] & ~32'h0000_0002;
      do_reset();
      // every word clears on reset
      for (int i = 0; i < 4; i++) begin
         axi_read(6'(i * 4), rd, rs);
         check32("ctrl reset", CTRL_RESET, rd);
      end
      axi_read(OFF_IRQ_STATUS, rd, rs);
      check32("status reset", 32'h0000_0000, rd);
      check1("irq reset", 1'b0, irq);
      // fill: foreign channel bits, reserved bits and end flag stay zero
      for (int i = 0; i < 4; i++) begin
         axi_write(6'(i * 4), wr_word[i], rs);
         check32("write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
         axi_read(6'(i * 4), rd, rs);
         check32("ctrl fill", exp_word[i], rd);
      end
      check1("ch3 indirect", 1'b1, fields[3].indirect_addressing_select);
      check1("ch0 indirect", 1'b0, fields[0].indirect_addressing_select);
      check1("ch2 reload", 1'b1, fields[2].source_reload_select);
      check1("ch3 reload", 1'b0, fields[3].source_reload_select);
      check1("ch1 sense", 1'b1, fields[1].request_sense_select);
      check1("ch2 sense", 1'b0, fields[2].request_sense_select);
      // end pulses on channels 1 and 3 set flags and status; masked so no interrupt yet
      done <= 4'hA;
      @(posedge sys_clk_in);
      done <= 4'h0;
      repeat (3) @(posedge sys_clk_in);
      axi_read(OFF_CTRL1, rd, rs);
      check32("flag set", exp_word[1] | 32'h2, rd);
      check1("ch3 flag", 1'b1, fields[3].transfer_end_flag);
      axi_read(OFF_IRQ_STATUS, rd, rs);
      check32("status set", 32'h0000_000A, rd);
      check1("irq masked", 1'b0, irq);
      axi_write(OFF_IRQ_MASK, 32'h0000_000F, rs);
      repeat (3) @(posedge sys_clk_in);
      check1("irq unmasked", 1'b1, irq);
      // writing one leaves the flag, writing zero clears it
      axi_write(OFF_CTRL1, exp_word[1] | 32'h2, rs);
      axi_read(OFF_CTRL1, rd, rs);
      check32("flag kept", exp_word[1] | 32'h2, rd);
      axi_write(OFF_CTRL1, exp_word[1], rs);
      axi_read(OFF_CTRL1, rd, rs);
      check32("flag clear", exp_word[1], rd);
      axi_write(OFF_IRQ_STATUS, 32'h0000_000A, rs);
      repeat (3) @(posedge sys_clk_in);
      check1("irq cleared", 1'b0, irq);
      // unmapped offset
      axi_read(OFF_END_EVENT, rd, rs);
      check32("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      check32("unmapped rdata", 32'h0000_0000, rd);
      axi_write(OFF_END_EVENT, 32'h0000_0001, rs);
      check32("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      // reset in mid-run clears everything again
      do_reset();
      axi_read(OFF_CTRL3, rd, rs);
      check32("ctrl3 rereset", CTRL_RESET, rd);
      check1("ch3 indirect rst", 1'b0, fields[3].indirect_addressing_select);
      axi_read(OFF_IRQ_MASK, rd, rs);
      check32("mask rereset", 32'h0000_0000, rd);
      report_and_stop();
   end
endmodule : dma_channel_control_reg_tb
